// [rtl/rfe_pkg.sv]
// Purpose: constants and types for the receive front-end control bank
// Assumes: 4-bit address, 12-bit data serial frames, eight channels
// Notes: offsets are register addresses on the serial control port
//
// Functional notes
// - fine cutoff code applies only in fine mode
// - address 9 bits power down converters
// - address B bits 11:9 select output swing
// - address D bits 11:6 set clock delay
// - address F pointer selects readback register
// - power-up clears every control bit
// - default state powers every block on
// - imaging mode: channel-off bits power channels down
// - imaging mode ignores doppler switch registers
// - doppler mode shuts converters, filters, serial output
// - doppler switch fields enable channel transconductors
// - enabled channels sum onto selected output pair
// - two gain bits pick one of four
// - samples leave 5.5 sample clocks after capture
// - feedback switch bit closes internal switch
// - tracking trigger runs filter calibration in imaging mode only, shifts cutoff
// - mode bit is address 6 bit 8
// - two six-bit switch fields per register
// - channel-off field is address 6 bits 7:0
package rfe_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 12;
  localparam int NCH = 8;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_CNT = 5'h10;
  localparam logic [4:0] DATA_CNT = 5'h04;
  localparam logic [11:0] REG_RST = 12'h000;
  localparam logic [3:0] OFS_CW_BASE = 4'h2;
  localparam logic [3:0] OFS_MODE = 4'h6;
  localparam logic [3:0] OFS_AAF_LO = 4'h7;
  localparam logic [3:0] OFS_AAF_HI = 4'h8;
  localparam logic [3:0] OFS_CONVERTER_CHANNEL_POWER_DOWN = 4'h9;
  localparam logic [3:0] OFS_SWING = 4'hb;
  localparam logic [3:0] OFS_DLY = 4'hd;
  localparam logic [3:0] OFS_PTR = 4'hf;
  localparam int MODE_BIT = 8;
  localparam int AAF_MODE_LSB = 8;
  localparam int TRACKING_TRIGGER_BIT = 5;
  localparam int FBSW_BIT = 3;
  localparam int LNAG_BIT = 2;
  localparam int SWING_LSB = 9;
  localparam int DLY_LSB = 6;
  localparam int PTR_LSB = 8;
  localparam int CW_EN_BIT = 5;
  localparam int CW_SE_BIT = 4;
  localparam int CW_NEG_BIT = 3;
  localparam logic [1:0] AAF_FINE = 2'h2;
  // ref clock runs at twice the sample rate: 11 ticks = 5.5 samples
  localparam int LAT_STAGES = 11;
  typedef enum logic [0:0] {
    RFE_IDLE = 1'b0,
    RFE_SHIFT = 1'b1
  } rfe_state_t;
endpackage : rfe_pkg

// [rtl/rfe_ctrl_top.sv]
// Purpose: serial-programmed mode and power control register bank
// Assumes: serial clock idles low, data sampled on its rising edge
// Notes: all serial pins are resynchronised to ref_clk_in
module rfe_ctrl_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // serial control port
  input wire logic spi_sclk_in,
  input wire logic spi_sel_n_in,
  input wire logic spi_sdata_in,
  output logic spi_sdout_out,
  output logic spi_sdout_oe_out,
  // external trigger and sample strobe
  input wire logic tracking_trigger_in,
  input wire logic conv_strobe_in,
  // power control
  output logic path_mode_select_out,
  output logic [rfe_pkg::NCH-1:0] lna_pd_out,
  output logic [rfe_pkg::NCH-1:0] vga_aaf_pd_out,
  output logic [rfe_pkg::NCH-1:0] adc_pd_out,
  output logic pll_en_out,
  output logic lvds_en_out,
  // doppler path
  output logic [rfe_pkg::NCH-1:0] cw_on_out,
  output logic [rfe_pkg::NCH-1:0] doppler_output_pos_out,
  output logic [rfe_pkg::NCH-1:0] doppler_output_neg_out,
  // filter and gain
  output logic [3:0] filter_fine_code_out,
  output logic filter_fine_en_out,
  output logic [1:0] filter_cutoff_mode_out,
  output logic tracking_run_out,
  output logic [1:0] gain_select_out,
  output logic lna_gain_low_out,
  output logic feedback_switch_control_out,
  // serial output shaping
  output logic [2:0] swing_code_out,
  output logic [5:0] clock_output_delay_code_out,
  output logic sample_valid_out
);
  import rfe_pkg::*;

  function automatic logic [5:0] cw_field(input logic [11:0] w,
                                          input int hi);
    cw_field = hi[0] ? w[11:6] : w[5:0];
  endfunction : cw_field

  logic [11:0] regs_r [16];
  // synchronisers: stage m feeds stage s only
  logic sclk_m_r, sclk_s_r, sclk_d_r;
  logic sel_m_r, sel_s_r;
  logic sdi_m_r, sdi_s_r;
  logic trig_m_r, trig_s_r;
  rfe_state_t state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [11:0] rd_sh_r, rd_sh_nxt;
  logic sdo_r, sdo_nxt;
  logic oe_nxt;
  logic [LAT_STAGES-1:0] lat_r;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      sclk_m_r <= 1'b0;
      sclk_s_r <= 1'b0;
      sclk_d_r <= 1'b0;
      sel_m_r <= 1'b1;
      sel_s_r <= 1'b1;
      sdi_m_r <= 1'b0;
      sdi_s_r <= 1'b0;
      trig_m_r <= 1'b0;
      trig_s_r <= 1'b0;
    end else begin
      sclk_m_r <= spi_sclk_in;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      sel_m_r <= spi_sel_n_in;
      sel_s_r <= sel_m_r;
      sdi_m_r <= spi_sdata_in;
      sdi_s_r <= sdi_m_r;
      trig_m_r <= tracking_trigger_in;
      trig_s_r <= trig_m_r;
    end
  end

  // serial frame decode
  wire sclk_rise = sclk_s_r & ~sclk_d_r;
  wire sclk_fall = ~sclk_s_r & sclk_d_r;
  wire in_frame = (state_r == RFE_SHIFT) & ~sel_s_r;
  wire frame_start = (state_r == RFE_IDLE) & ~sel_s_r;
  wire frame_end = (state_r == RFE_SHIFT) & sel_s_r;
  wire take_bit = in_frame & sclk_rise & (cnt_r < FRAME_CNT);
  wire give_bit = in_frame & sclk_fall & (cnt_r >= DATA_CNT)
                  & (cnt_r < FRAME_CNT);
  // short frames are dropped; bits past the sixteenth are ignored
  wire wr_en = frame_end & (cnt_r == FRAME_CNT);
  wire [3:0] wr_addr = sh_r[15:12];
  wire [11:0] wr_data = sh_r[11:0];
  wire [3:0] rd_ptr = regs_r[OFS_PTR][PTR_LSB+3:PTR_LSB];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RFE_IDLE: begin
        if (frame_start) begin
          state_nxt = RFE_SHIFT;
        end
      end
      RFE_SHIFT: begin
        if (frame_end) begin
          state_nxt = RFE_IDLE;
        end
      end
      default: begin
        state_nxt = RFE_IDLE;
      end
    endcase
  end

  assign cnt_nxt = frame_start ? 5'h00 :
                   take_bit ? cnt_r + 5'h01 : cnt_r;
  assign sh_nxt = take_bit ? {sh_r[14:0], sdi_s_r} : sh_r;
  // word under the pointer is latched at frame start
  assign rd_sh_nxt = frame_start ? regs_r[rd_ptr] :
                     give_bit ? {rd_sh_r[10:0], 1'b0} : rd_sh_r;
  assign sdo_nxt = give_bit ? rd_sh_r[11] :
                   frame_start ? 1'b0 : sdo_r;
  assign oe_nxt = (state_nxt == RFE_SHIFT);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_r <= RFE_IDLE;
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
      rd_sh_r <= 12'h000;
      sdo_r <= 1'b0;
      spi_sdout_oe_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      rd_sh_r <= rd_sh_nxt;
      sdo_r <= sdo_nxt;
      spi_sdout_oe_out <= oe_nxt;
    end
  end

  assign spi_sdout_out = sdo_r;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < 16; i++) begin
        regs_r[i] <= REG_RST;
      end
    end else if (wr_en) begin
      regs_r[wr_addr] <= wr_data;
    end
  end

  // mode and field decode
  wire mode_cw = regs_r[OFS_MODE][MODE_BIT];
  wire [7:0] imaging_channel_off_field = regs_r[OFS_MODE][7:0];
  wire [7:0] converter_channel_power_down = regs_r[OFS_CONVERTER_CHANNEL_POWER_DOWN][7:0];
  wire [1:0] aaf_mode = regs_r[OFS_AAF_LO][AAF_MODE_LSB+1:AAF_MODE_LSB];
  wire [3:0] aaf_fine = regs_r[OFS_AAF_HI][3:0];
  wire fine_sel = (aaf_mode == AAF_FINE);
  logic [7:0] cw_on;
  logic [7:0] pos_act, neg_act;

  // per-channel switch fields; two channels share a register
  always_comb begin
    logic [5:0] f;
    f = 6'h00;
    cw_on = 8'h00;
    pos_act = 8'h00;
    neg_act = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      f = cw_field(regs_r[OFS_CW_BASE + 4'(i / 2)], i % 2);
      // switch fields count only in doppler mode
      cw_on[i] = mode_cw & f[CW_EN_BIT];
      // currents of channels on one pair are summed there
      pos_act[f[2:0]] = pos_act[f[2:0]] | (cw_on[i] &
        (~f[CW_SE_BIT] | ~f[CW_NEG_BIT]));
      neg_act[f[2:0]] = neg_act[f[2:0]] | (cw_on[i] &
        (~f[CW_SE_BIT] | f[CW_NEG_BIT]));
    end
  end

  // imaging mode uses channel-off bits; doppler ignores them
  wire [7:0] lna_pd_nxt = mode_cw ? ~cw_on : imaging_channel_off_field;
  wire [7:0] vga_pd_nxt = mode_cw ? 8'hff : imaging_channel_off_field;
  wire [7:0] adc_pd_nxt = mode_cw ? 8'hff : converter_channel_power_down;
  wire [3:0] fine_nxt = fine_sel ? aaf_fine : 4'h0;
  // the filter is idle in doppler mode, so tracking would only add noise
  wire track_nxt = (regs_r[OFS_AAF_LO][TRACKING_TRIGGER_BIT] | trig_s_r)
                   & ~mode_cw;
  wire [LAT_STAGES-1:0] lat_nxt = {lat_r[LAT_STAGES-2:0],
                                   conv_strobe_in & ~mode_cw};

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      path_mode_select_out <= 1'b0;
      lna_pd_out <= 8'h00;
      vga_aaf_pd_out <= 8'h00;
      adc_pd_out <= 8'h00;
      pll_en_out <= 1'b1;
      lvds_en_out <= 1'b1;
      cw_on_out <= 8'h00;
      doppler_output_pos_out <= 8'h00;
      doppler_output_neg_out <= 8'h00;
      filter_fine_code_out <= 4'h0;
      filter_fine_en_out <= 1'b0;
      filter_cutoff_mode_out <= 2'h0;
      tracking_run_out <= 1'b0;
      gain_select_out <= 2'h0;
      lna_gain_low_out <= 1'b0;
      feedback_switch_control_out <= 1'b0;
      swing_code_out <= 3'h0;
      clock_output_delay_code_out <= 6'h00;
      lat_r <= '0;
    end else begin
      path_mode_select_out <= mode_cw;
      lna_pd_out <= lna_pd_nxt;
      vga_aaf_pd_out <= vga_pd_nxt;
      adc_pd_out <= adc_pd_nxt;
      pll_en_out <= ~mode_cw;
      lvds_en_out <= ~mode_cw;
      cw_on_out <= cw_on;
      doppler_output_pos_out <= pos_act;
      doppler_output_neg_out <= neg_act;
      filter_fine_code_out <= fine_nxt;
      filter_fine_en_out <= fine_sel;
      filter_cutoff_mode_out <= aaf_mode;
      tracking_run_out <= track_nxt;
      gain_select_out <= regs_r[OFS_AAF_LO][1:0];
      lna_gain_low_out <= regs_r[OFS_AAF_LO][LNAG_BIT];
      feedback_switch_control_out <=
        regs_r[OFS_AAF_LO][FBSW_BIT];
      swing_code_out <= regs_r[OFS_SWING][SWING_LSB+2:SWING_LSB];
      clock_output_delay_code_out <=
        regs_r[OFS_DLY][DLY_LSB+5:DLY_LSB];
      lat_r <= lat_nxt;
    end
  end

  assign sample_valid_out = lat_r[LAT_STAGES-1];

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  a_frame_write: assert property (
    wr_en |=> regs_r[$past(wr_addr)] == $past(wr_data))
    else $error("frame data not stored");

  a_readback_load: assert property (
    frame_start |=> rd_sh_r == $past(regs_r[rd_ptr]))
    else $error("readback word not loaded");

  a_cw_shutdown: assert property (
    mode_cw |=> adc_pd_out == 8'hff && vga_aaf_pd_out == 8'hff
                && !pll_en_out && !lvds_en_out)
    else $error("doppler mode left blocks powered");

  a_tgc_imaging_channel_off_field: assert property (
    !mode_cw |=> lna_pd_out == $past(imaging_channel_off_field)
                 && vga_aaf_pd_out == $past(imaging_channel_off_field))
    else $error("channel-off field not applied");

  a_tgc_ignore_cw: assert property (
    !mode_cw |=> cw_on_out == 8'h00 && doppler_output_pos_out == 8'h00)
    else $error("doppler switch active in imaging mode");

  a_adc_pd_map: assert property (
    !mode_cw |=> adc_pd_out == $past(converter_channel_power_down))
    else $error("converter power-down mismatch");

  a_fine_gate: assert property (
    !fine_sel |=> filter_fine_code_out == 4'h0 && !filter_fine_en_out)
    else $error("fine code applied outside fine mode");

  a_swing_delay: assert property (
    $changed(regs_r[OFS_SWING]) |=> swing_code_out ==
      $past(regs_r[OFS_SWING][SWING_LSB+2:SWING_LSB]))
    else $error("swing code not followed");

  sequence s_conv;
    conv_strobe_in && !mode_cw;
  endsequence

  sequence s_mode_steady;
    !mode_cw [*8];
  endsequence

  property p_latency;
    s_conv ##0 s_mode_steady |-> ##4 sample_valid_out;
  endproperty

  a_out_latency: assert property (p_latency)
    else $error("sample not delivered 11 ticks later");

  a_gain_select: assert property (
    ##1 gain_select_out == $past(regs_r[OFS_AAF_LO][1:0]))
    else $error("gain select mismatch");

  // a frame shorter than sixteen bits must leave the addressed register untouched
  a_short_drop: assert property (
    frame_end && cnt_r != FRAME_CNT |=> $stable(regs_r[wr_addr]))
    else $error("partial frame was stored");

  a_oe_open: assert property (
    frame_start |=> spi_sdout_oe_out)
    else $error("output enable missing in frame");

  a_oe_close: assert property (
    frame_end |=> !spi_sdout_oe_out)
    else $error("output enable left on after frame");

  a_sdo_shift: assert property (
    give_bit |=> spi_sdout_out == $past(rd_sh_r[11]))
    else $error("readback bit not driven");

  a_mode_follow: assert property (
    ##1 path_mode_select_out == $past(mode_cw))
    else $error("mode output does not follow bit");

  a_cw_lna_pd: assert property (
    mode_cw |=> lna_pd_out == ~$past(cw_on))
    else $error("doppler amplifier power mismatch");

  a_track_off: assert property (
    mode_cw |=> !tracking_run_out)
    else $error("tracking ran in doppler mode");

  a_fine_apply: assert property (
    fine_sel |=> filter_fine_en_out
                 && filter_fine_code_out == $past(aaf_fine))
    else $error("fine code not applied");

  a_delay_code: assert property (
    $changed(regs_r[OFS_DLY]) |=> clock_output_delay_code_out ==
      $past(regs_r[OFS_DLY][DLY_LSB+5:DLY_LSB]))
    else $error("delay code not followed");

  a_fbsw_follow: assert property (
    $changed(regs_r[OFS_AAF_LO]) |=> feedback_switch_control_out ==
      $past(regs_r[OFS_AAF_LO][FBSW_BIT]))
    else $error("feedback switch bit not followed");

endmodule : rfe_ctrl_top

// [verification/rfe_host_model.sv]
// Purpose: host model driving the serial control port
// Assumes: 125 ns serial clock that stands low between frames
// Notes: idle data line shows the inverse of its last bit
module rfe_host_model (
  // serial port
  output logic sclk_out,
  output logic sel_n_out,
  output logic sdata_out,
  input wire logic sdout_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    sdata_out = 1'b0;
  end
  // nbits below 16 lets the bench send a frame the device must drop
  task automatic xfer(input logic [3:0] a, input logic [11:0] d,
                      input int nbits, output logic [11:0] q);
    logic [15:0] w;
    w = {a, d};
    q = 12'h000;
    sel_n_out = 1'b0;
    #100;
    for (int i = 1; i <= nbits; i++) begin
      sdata_out = w[15];
      w = {w[14:0], 1'b0};
      #62.5;
      sclk_out = 1'b1;
      if (i >= 5) q = {q[10:0], sdout_in};
      #62.5;
      sclk_out = 1'b0;
    end
    #62.5;
    sel_n_out = 1'b1;
    sdata_out = ~sdata_out;
    // gap covers the select sync and the write-back
    #150;
  endtask : xfer
endmodule : rfe_host_model

// [verification/rfe_ctrl_top_tb_top.sv]
// Purpose: self-checking bench for the control register bank
// Assumes: host model owns the serial pins
// Notes: outputs are judged once each frame has been written back
module rfe_ctrl_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, sclk, sel_n, sdi, sdo, trig, stb, mode, pll, lvds;
  logic fen, trk, fbsw, sval, oe, lgl;
  logic [7:0] lna, vga, adc, cw, dp, dn;
  logic [3:0] fine;
  logic [1:0] gain, fcm;
  logic [2:0] swing;
  logic [5:0] dly;
  logic [11:0] q;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  rfe_host_model u_host (.sclk_out(sclk), .sel_n_out(sel_n),
    .sdata_out(sdi), .sdout_in(sdo));
  rfe_ctrl_top u_dut (.ref_clk_in(clk), .reset_in(rst),
    .spi_sclk_in(sclk), .spi_sel_n_in(sel_n), .spi_sdata_in(sdi),
    .spi_sdout_out(sdo), .spi_sdout_oe_out(oe), .tracking_trigger_in(trig),
    .conv_strobe_in(stb), .path_mode_select_out(mode), .lna_pd_out(lna),
    .vga_aaf_pd_out(vga), .adc_pd_out(adc), .pll_en_out(pll),
    .lvds_en_out(lvds), .cw_on_out(cw), .doppler_output_pos_out(dp),
    .doppler_output_neg_out(dn), .filter_fine_code_out(fine),
    .filter_fine_en_out(fen), .filter_cutoff_mode_out(fcm),
    .tracking_run_out(trk), .gain_select_out(gain),
    .lna_gain_low_out(lgl), .feedback_switch_control_out(fbsw),
    .swing_code_out(swing), .clock_output_delay_code_out(dly),
    .sample_valid_out(sval));
  always #5 clk = ~clk;
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    u_host.xfer(a, d, 16, q);
  endtask : wr
  // pointer first, answer comes on the following frame
  task automatic rd(input logic [3:0] a);
    wr(4'hf, {a, 8'h00});
    u_host.xfer(4'hf, {a, 8'h00}, 16, q);
  endtask : rd
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic t_reset;
    check("pll", pll, 1);
    check("lvds", lvds, 1);
    check("pd", {lna, vga, adc, mode}, 0);
    check("cfg", {swing, dly, cw}, 0);
    check("cutoff", {fcm, lgl}, 0);
    check("oe idle", oe, 0);
    for (int a = 0; a < 15; a++) begin
      rd(a[3:0]);
      check("reg", q, 0);
    end
    $display("done reset");
  endtask : t_reset
  task automatic t_regs;
    logic [3:0] ad [3] = '{4'h9, 4'hb, 4'hd};
    logic [11:0] dv [3] = '{12'h0a5, 12'ha00, 12'hfc0};
    for (int i = 0; i < 3; i++) wr(ad[i], dv[i]);
    check("adc", adc, 8'ha5);
    check("swing", swing, 3'h5);
    check("dly", dly, 6'h3f);
    for (int i = 0; i < 3; i++) begin
      rd(ad[i]);
      check("readback", q, dv[i]);
    end
    u_host.xfer(4'h9, 12'h0ff, 15, q);
    check("short frame", adc, 8'ha5);
    $display("done regs");
  endtask : t_regs
  task automatic t_filter;
    wr(4'h8, 12'h009);
    wr(4'h7, 12'h20f);
    check("fine", {fen, fine}, 5'h19);
    check("cutoff", fcm, 2'h2);
    check("gain", gain, 2'h3);
    check("fbsw", {fbsw, lgl}, 2'h3);
    wr(4'h7, 12'h100);
    check("coarse", {fen, fine, fbsw}, 0);
    check("cutoff 01", fcm, 2'h1);
    $display("done filter");
  endtask : t_filter
  task automatic t_imaging;
    wr(4'h6, 12'h07f);
    check("imaging_channel_off_field", {lna, vga}, 16'h7f7f);
    wr(4'h2, 12'h820);
    check("cw ignored", cw, 0);
    $display("done imaging");
  endtask : t_imaging
  task automatic t_doppler;
    @(negedge clk);
    trig = 1;
    wr(4'h6, 12'h17f);
    check("mode", mode, 1);
    check("off", {pll, lvds, adc, vga}, 18'h0ffff);
    check("cw", cw, 8'h03);
    check("sum", {dp, dn}, 16'h0101);
    check("lna", lna, 8'hfc);
    check("trk", trk, 0);
    wr(4'h6, 12'h000);
    check("trk img", trk, 1);
    @(negedge clk);
    trig = 0;
    $display("done doppler");
  endtask : t_doppler
  task automatic t_latency;
    @(negedge clk);
    stb = 1;
    @(negedge clk);
    stb = 0;
    // one cycle has already passed since the strobe was sampled
    n = 1;
    while (sval !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("latency", n, 11);
    $display("done latency");
  endtask : t_latency
  initial begin
    #400us;
    mismatches++;
    conclude();
  end
  initial begin
    clk = 0;
    rst = 1;
    trig = 0;
    stb = 0;
    repeat (12) @(negedge clk);
    rst = 0;
    @(negedge clk);
    t_reset();
    t_regs();
    t_filter();
    t_imaging();
    t_doppler();
    t_latency();
    conclude();
  end
endmodule : rfe_ctrl_top_tb_top
